// file: fsdf_ctrl.sv
// Summary of operation
// (RL1) serial erase refused under erase prohibition
// (RL2) serial write refused under write prohibition
// (RL3) boot cluster zero locked in both modes
// (RL4) all protections clear when shipped
// (RL5) protections independent, settable either mode
// (RL6) erase and boot lock never clear
// (RL7) release only serial, others clear, blank
// (RL8) write release effective after next reset
// (RL9) data flash erased in 1-Kbyte blocks
// (RL10) data flash byte-wide, read by cpu
// (RL11) no data flash fetch, code runs meanwhile
// (RL12) data flash blocked during code rewrite
// (RL13) control writes ignored during data rewrite
// (RL14) stop refused during data rewrite
// (RL15) control register resets to zero
// (RL16) bit zero enables data flash access
// (RL17) software waits setup after enabling
// (RL18) clear enable before stop in setup
// (RL19) dummy read after subsystem clock switch
// (RL20) software holds dma before reading
// (RL21) nop before data flash read alternative
// (RL22) fast oscillator running during rewrite
// (RL23) refused serial command reports error
//
// Purpose: flash security gate and data flash access control
// Assumes: nv security bits are loaded by fuse logic outside; the flash
//   array engine runs commands when ans.go pulses and reports busy
// Notes: the security word is nonvolatile; sec_nv is what the array holds
//   a granted release stays pending across later sets that leave the write bit clear, until the next reset
module fsdf_ctrl
  import fsdf_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input wire logic clk,
  input wire logic rst,
  // security word loaded from nonvolatile store
  input wire fsdf_sec_t sec_nv,
  // flash array blank status
  input wire logic code_blank,
  input wire logic data_blank,
  // command request
  input wire logic req_valid,
  input wire fsdf_req_t req,
  output fsdf_ans_t ans,
  output logic ans_valid,
  output fsdf_sec_t sec_wr_data,
  output logic sec_wr,
  // array activity from the flash engine
  input wire logic code_rewrite,
  input wire logic df_rewrite,
  // cpu register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // cpu data flash access
  input wire logic df_rd,
  input wire logic df_fetch,
  output logic df_grant,
  output logic df_fetch_err,
  // stop gating
  input wire logic stop_req,
  output logic stop_ok,
  // effective protections
  output fsdf_sec_t sec_active
);

  //////////////////////////////////////////////////////////////////////
  // security state
  fsdf_sec_t sec_r, sec_nxt;
  fsdf_sec_t sec_cur;
  logic load_r, load_nxt;
  fsdf_ans_t ans_r, ans_nxt;
  logic ans_valid_r, ans_valid_nxt;
  fsdf_sec_t sec_wr_data_r, sec_wr_data_nxt;
  logic sec_wr_r, sec_wr_nxt;
  logic rel_pend_r, rel_pend_nxt;
  fsdf_status_t status_pick;
  logic in_bc0;
  logic erase_prot;
  logic write_prot;
  logic is_set;
  logic is_rel;
  logic rel_ok;
  logic df_aligned;

  //////////////////////////////////////////////////////////////////////
  // request decode
  // boot cluster zero is the low code flash range
  assign in_bc0 = (req.addr >= FSDF_BC0_LO) && (req.addr <= FSDF_BC0_HI);
  // stored word joins on the first edge after reset; decide on it already then,
  // otherwise a request on that edge would slip past every protection
  assign sec_cur = load_r ? (sec_r | sec_nv) : sec_r;
  assign is_set = (req.cmd == FSDF_CMD_SET_SEC);
  assign is_rel = (req.cmd == FSDF_CMD_RELEASE);
  // (RL9) whole 1-Kbyte blocks only
  assign df_aligned = (req.addr[FSDF_DF_BLOCK_SHIFT-1:0] == '0);
  // (RL7) release only serial, others clear, blank
  assign rel_ok = req.serial && !sec_cur.erase && !sec_cur.boot0 && code_blank && data_blank;

  // (RL1) (RL3) block erase gate
  fsdf_rewrite_gate erase_gate_u (
    .in_boot(in_bc0),
    .boot_lock(sec_cur.boot0),
    .serial(req.serial),
    .prohibit(sec_cur.erase),
    .refuse(erase_prot)
  );

  // (RL2) (RL3) code flash write gate
  fsdf_rewrite_gate write_gate_u (
    .in_boot(in_bc0),
    .boot_lock(sec_cur.boot0),
    .serial(req.serial),
    .prohibit(sec_cur.wr),
    .refuse(write_prot)
  );

  //////////////////////////////////////////////////////////////////////
  // command decision; only looked at while req_valid is high
  always_comb begin
    status_pick = FSDF_ST_OK;
    unique case (req.cmd)
      FSDF_CMD_ERASE: begin
        if (erase_prot) begin
          status_pick = FSDF_ST_PROT;
        end
      end
      FSDF_CMD_WRITE: begin
        if (write_prot) begin
          status_pick = FSDF_ST_PROT;
        end
      end
      FSDF_CMD_DF_ERASE: begin
        if (!df_aligned) begin
          status_pick = FSDF_ST_BADARG;
        end
      end
      // (RL5) set accepted in either mode
      FSDF_CMD_SET_SEC: begin
        status_pick = FSDF_ST_OK;
      end
      FSDF_CMD_RELEASE: begin
        if (!rel_ok) begin
          status_pick = FSDF_ST_DENY;
        end
      end
      // three codes are unused
      default: begin
        status_pick = FSDF_ST_BADARG;
      end
    endcase
  end

  // answer one cycle after the request, valid as a pulse
  always_comb begin
    ans_nxt = '0;
    ans_valid_nxt = 1'b0;
    if (req_valid) begin
      ans_valid_nxt = 1'b1;
      // (RL23) refused commands report status
      ans_nxt.status = status_pick;
      ans_nxt.go = (status_pick == FSDF_ST_OK) && !is_set && !is_rel; // engine idle otherwise
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ans_r <= '0;
      ans_valid_r <= 1'b0;
    end else begin
      ans_r <= ans_nxt;
      ans_valid_r <= ans_valid_nxt;
    end
  end

  // live protections only gain bits until the next reset
  always_comb begin
    load_nxt = 1'b0;
    sec_nxt = sec_cur;
    if (req_valid && is_set) begin
      // (RL5) (RL6) independent bits, only added
      sec_nxt = sec_cur | req.sec;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // (RL4) (RL8) all clear until loaded
      sec_r <= '0;
      load_r <= 1'b1;
    end else begin
      sec_r <= sec_nxt;
      load_r <= load_nxt;
    end
  end

  // stored word follows every set; a release clears it for the next reset
  always_comb begin
    sec_wr_nxt = 1'b0;
    sec_wr_data_nxt = sec_wr_data_r;
    rel_pend_nxt = rel_pend_r;
    if (req_valid && is_set) begin
      sec_wr_nxt = 1'b1;
      sec_wr_data_nxt = sec_cur | req.sec;
      // a later set must not quietly undo a pending release of the write lock
      if (rel_pend_r && !req.sec.wr) begin
        sec_wr_data_nxt.wr = 1'b0;
      end
      if (req.sec.wr) begin
        rel_pend_nxt = 1'b0;
      end
    end else if (req_valid && is_rel && rel_ok) begin
      // (RL8) stored copy cleared, live kept
      sec_wr_nxt = 1'b1;
      sec_wr_data_nxt = '{boot0: 1'b0, wr: 1'b0, erase: 1'b0};
      rel_pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sec_wr_data_r <= '0;
      sec_wr_r <= 1'b0;
      rel_pend_r <= 1'b0;
    end else begin
      sec_wr_data_r <= sec_wr_data_nxt;
      sec_wr_r <= sec_wr_nxt;
      rel_pend_r <= rel_pend_nxt;
    end
  end

  // outputs straight from the flops
  assign ans = ans_r;
  assign ans_valid = ans_valid_r;
  assign sec_wr_data = sec_wr_data_r;
  assign sec_wr = sec_wr_r;
  assign sec_active = sec_r;

  //////////////////////////////////////////////////////////////////////
  // data flash control register
  logic en_r, en_nxt;
  logic ctl_hit;

  assign ctl_hit = (reg_addr == ADDR_W'(FSDF_CTL_ADDR));

  always_comb begin
    en_nxt = en_r;
    // (RL13) locked while data flash rewrites
    if (reg_wr && ctl_hit && !df_rewrite) begin
      // (RL16) bit zero is the enable
      en_nxt = reg_wdata[FSDF_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // (RL15) reset to zero
      en_r <= FSDF_CTL_RESET[FSDF_EN_BIT];
    end else begin
      en_r <= en_nxt;
    end
  end

  // upper bits always read zero
  always_comb begin
    reg_rdata = 8'h00;
    if (ctl_hit) begin
      reg_rdata[FSDF_EN_BIT] = en_r;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // data flash access gating
  // (RL10) (RL12) byte reads granted when enabled and no code rewrite
  assign df_grant = df_rd && en_r && !code_rewrite;
  // (RL11) fetch never served, code fetch unaffected by df_rewrite
  assign df_fetch_err = df_fetch;
  // (RL14) stop held off during rewrite
  assign stop_ok = stop_req && !df_rewrite;

endmodule

//////////////////////////////////////////////////////////////////////
// one rewrite gate: boot cluster lock in every mode, prohibition on serial only
module fsdf_rewrite_gate (
  input wire logic in_boot,
  input wire logic boot_lock,
  input wire logic serial,
  input wire logic prohibit,
  output logic refuse
);

  logic boot_hit;
  logic serial_hit;

  // (RL3) boot cluster refused both modes
  assign boot_hit = boot_lock && in_boot;
  // (RL1) (RL2) self-programming bypasses prohibition
  assign serial_hit = prohibit && serial;
  // boot lock is checked first but either hit refuses
  assign refuse = boot_hit || serial_hit;

endmodule

// file: fsdf_pkg.sv
// Purpose: shared constants and carriers for flash security and data flash access
// Assumes: byte-wide cpu register port, one clock, synchronous reset
// Notes: addresses are 20-bit cpu space addresses
package fsdf_pkg;

  localparam logic [19:0] FSDF_CTL_ADDR = 20'hf0090;
  localparam logic [7:0] FSDF_CTL_RESET = 8'h00;
  localparam int FSDF_EN_BIT = 0;

  // boot cluster zero range
  localparam logic [19:0] FSDF_BC0_LO = 20'h00000;
  localparam logic [19:0] FSDF_BC0_HI = 20'h00fff;

  // data flash erase block size in bytes
  localparam int FSDF_DF_BLOCK_BYTES = 1024;
  localparam int FSDF_DF_BLOCK_SHIFT = 10;

  // programmer command codes
  typedef enum logic [2:0] {
    FSDF_CMD_ERASE = 3'h0,
    FSDF_CMD_WRITE = 3'h1,
    FSDF_CMD_SET_SEC = 3'h2,
    FSDF_CMD_RELEASE = 3'h3,
    FSDF_CMD_DF_ERASE = 3'h4
  } fsdf_cmd_t;

  // command answer status
  typedef enum logic [1:0] {
    FSDF_ST_OK = 2'h0,
    FSDF_ST_PROT = 2'h1,
    FSDF_ST_DENY = 2'h2,
    FSDF_ST_BADARG = 2'h3
  } fsdf_status_t;

  // security settings as one word
  typedef struct packed {
    logic boot0;
    logic wr;
    logic erase;
  } fsdf_sec_t;

  // command request from programmer or firmware
  typedef struct packed {
    fsdf_cmd_t cmd;
    logic serial;
    logic [19:0] addr;
    fsdf_sec_t sec;
  } fsdf_req_t;

  // command answer
  typedef struct packed {
    logic go;
    fsdf_status_t status;
  } fsdf_ans_t;

endpackage

// file: fsdf_nv_model.sv
// Purpose: security word store beside fsdf_ctrl
// Assumes: one write pulse per change
// Notes: blank as shipped
module fsdf_nv_model
  import fsdf_pkg::*;
(
  input wire logic clk,
  input wire logic sec_wr,
  input wire fsdf_sec_t sec_wr_data,
  output fsdf_sec_t sec_nv
);
  timeunit 1ns;
  timeprecision 100ps;
  initial sec_nv = '0;
  // word kept for the next reset
  always @(posedge clk) if (sec_wr) sec_nv <= sec_wr_data;
endmodule

// file: fsdf_ctrl_assertions.sv
// Purpose: port checks for fsdf_ctrl
// Assumes: one clock, sync reset
// Notes: bound into every fsdf_ctrl
module fsdf_ctrl_chk
  import fsdf_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire fsdf_req_t req,
  input wire fsdf_ans_t ans,
  input wire logic ans_valid,
  input wire fsdf_sec_t sec_active,
  input wire logic code_blank,
  input wire logic data_blank,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic df_rd,
  input wire logic df_grant,
  input wire logic code_rewrite,
  input wire logic df_rewrite,
  input wire logic stop_req,
  input wire logic stop_ok
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // array command and control address decodes
  wire logic ew = req_valid && (req.cmd == FSDF_CMD_ERASE || req.cmd == FSDF_CMD_WRITE);
  wire logic ctl = (reg_addr == FSDF_CTL_ADDR);
  sequence s_prot; ans.status == FSDF_ST_PROT && !ans.go; endsequence
  sequence s_ctl_wr; reg_wr && ctl && !df_rewrite; endsequence
  sequence s_lock; reg_wr && ctl && df_rewrite ##1 ctl; endsequence
  ////////////////////////////////
  property p_ans; req_valid |=> ans_valid; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_ers; ew && req.serial && req.cmd == FSDF_CMD_ERASE && sec_active.erase |=> s_prot;
  endproperty
  a_ers: assert property (p_ers) else $error("erase passed");
  property p_wr; ew && req.serial && req.cmd == FSDF_CMD_WRITE && sec_active.wr |=> s_prot;
  endproperty
  a_wr: assert property (p_wr) else $error("write passed");
  property p_bc0; ew && sec_active.boot0 && req.addr <= FSDF_BC0_HI |=> s_prot; endproperty
  a_bc0: assert property (p_bc0) else $error("boot area changed");
  property p_keep; sec_active.erase || sec_active.boot0 |=>
    $past(sec_active.erase) <= sec_active.erase && $past(sec_active.boot0) <= sec_active.boot0;
  endproperty
  a_keep: assert property (p_keep) else $error("lock cleared");
  property p_rel; req_valid && req.cmd == FSDF_CMD_RELEASE && (!req.serial || sec_active.erase
    || sec_active.boot0 || !code_blank || !data_blank) |=> ans.status == FSDF_ST_DENY;
  endproperty
  a_rel: assert property (p_rel) else $error("release passed");
  property p_ctl; s_ctl_wr ##1 ctl |-> reg_rdata[0] == $past(reg_wdata[0]) && !reg_rdata[7:1];
  endproperty
  a_ctl: assert property (p_ctl) else $error("enable wrong");
  property p_lock; s_lock |-> $stable(reg_rdata); endproperty
  a_lock: assert property (p_lock) else $error("write in rewrite");
  property p_gnt; df_grant |-> df_rd && !code_rewrite; endproperty
  a_gnt: assert property (p_gnt) else $error("grant wrong");
  property p_stop; stop_ok == (stop_req && !df_rewrite); endproperty
  a_stop: assert property (p_stop) else $error("stop wrong");
endmodule

bind fsdf_ctrl fsdf_ctrl_chk #(.ADDR_W(ADDR_W)) chk_u (.clk, .rst, .req_valid, .req, .ans,
  .ans_valid, .sec_active, .code_blank, .data_blank, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rdata, .df_rd, .df_grant, .code_rewrite, .df_rewrite, .stop_req, .stop_ok);

// file: fsdf_ctrl_tb_top.sv
// Purpose: bench for fsdf_ctrl
// Assumes: 200 MHz clock, sync reset
// Notes: answers expected from an int model
module fsdf_ctrl_tb_top import fsdf_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, req_valid, code_blank, data_blank, code_rewrite, df_rewrite, reg_wr;
  logic df_rd, df_fetch, stop_req, ans_valid, sec_wr, df_grant, df_fetch_err, stop_ok;
  fsdf_req_t req;
  fsdf_ans_t ans;
  fsdf_sec_t sec_nv, sec_wr_data, sec_active;
  logic [19:0] reg_addr, ra;
  logic [7:0] reg_wdata, reg_rdata;
  int fails, n_tests, cyc_n, es, ws, bs, wnv;
  fsdf_ctrl dut_u (.clk, .rst, .sec_nv, .code_blank, .data_blank, .req_valid, .req, .ans,
    .ans_valid, .sec_wr_data, .sec_wr, .code_rewrite, .df_rewrite, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rdata, .df_rd, .df_fetch, .df_grant, .df_fetch_err, .stop_req, .stop_ok,
    .sec_active);
  fsdf_nv_model nv_u (.clk, .sec_wr, .sec_wr_data, .sec_nv);
  ////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n > 2000) begin
      fails++;
      finish_test;
    end
  end
  task finish_test;
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t got %h want %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task do_rst;
    rst = 1;
    repeat (4) tick;
    rst = 0;
    ws = wnv;
    tick;
  endtask
  // one command, answer one cycle later
  task cmd(input fsdf_cmd_t c, input logic s, input logic [19:0] a, input fsdf_sec_t q);
    int st;
    int bc;
    bc = (a <= 20'h00fff);
    case (c)
      FSDF_CMD_ERASE, FSDF_CMD_WRITE: st = ((bs && bc) || (s && (c == FSDF_CMD_ERASE ? es : ws)));
      FSDF_CMD_RELEASE: st = (s && !es && !bs && code_blank && data_blank) ? 0 : 2;
      FSDF_CMD_DF_ERASE: st = (a % 1024) ? 3 : 0;
      default: st = 0;
    endcase
    tick;
    req = '{c, s, a, q};
    req_valid = 1;
    tick;
    req_valid = 0;
    if (c == FSDF_CMD_SET_SEC) begin
      es = es | q.erase;
      ws = ws | q.wr;
      bs = bs | q.boot0;
      wnv = wnv | q.wr;
    end
    if (c == FSDF_CMD_RELEASE && st == 0) wnv = 0;
    chk(ans_valid, 1);
    chk(ans.status, 8'(st));
    chk(ans.go, 8'(st == 0 && c != FSDF_CMD_SET_SEC && c != FSDF_CMD_RELEASE));
    chk(sec_wr, 8'(c == FSDF_CMD_SET_SEC || (c == FSDF_CMD_RELEASE && st == 0)));
    chk(sec_active, 8'(bs * 4 + ws * 2 + es));
  endtask
  ////////////////////////////////
  initial begin
    {rst, req_valid, code_rewrite, df_rewrite, reg_wr, df_rd, df_fetch, stop_req} = 8'h80;
    {code_blank, data_blank, req, reg_wdata} = '0;
    reg_addr = FSDF_CTL_ADDR;
    {fails, n_tests, cyc_n, es, ws, bs, wnv} = '0;
    void'($urandom(32'h44b1));
    ra = 20'h01000 + 20'($urandom % 32'h3000);
    do_rst;
    chk(sec_active, 0);
    chk(reg_rdata, 0);
    cmd(FSDF_CMD_ERASE, 1, ra, 0);
    cmd(FSDF_CMD_SET_SEC, 0, 0, 3'b010);
    cmd(FSDF_CMD_WRITE, 1, ra, 0);
    cmd(FSDF_CMD_WRITE, 0, ra, 0);
    cmd(FSDF_CMD_RELEASE, 1, 0, 0);
    {code_blank, data_blank} = 2'b11;
    cmd(FSDF_CMD_RELEASE, 0, 0, 0);
    cmd(FSDF_CMD_RELEASE, 1, 0, 0);
    do_rst;
    cmd(FSDF_CMD_SET_SEC, 1, 0, 3'b101);
    cmd(FSDF_CMD_ERASE, 1, ra, 0);
    cmd(FSDF_CMD_ERASE, 0, ra, 0);
    cmd(FSDF_CMD_WRITE, 0, 20'h00fff, 0);
    cmd(FSDF_CMD_RELEASE, 1, 0, 0);
    do_rst;
    chk(sec_active, 8'h05);
    cmd(FSDF_CMD_DF_ERASE, 0, 20'hf1400, 0);
    cmd(FSDF_CMD_DF_ERASE, 0, 20'hf1401, 0);
    // control register, access gating, stop
    {reg_addr, reg_wdata, reg_wr} = {FSDF_CTL_ADDR, 8'hff, 1'b1};
    tick;
    reg_wr = 0;
    chk(reg_rdata, 8'h01);
    repeat (144) tick;
    // main clock, dma held three clocks
    repeat (3) tick;
    df_rd = 1;
    tick;
    chk(df_grant, 1);
    {code_rewrite, df_rewrite, stop_req, reg_wr, reg_wdata} = {4'hf, 8'h00};
    tick;
    reg_wr = 0;
    chk(df_grant, 0);
    chk(stop_ok, 0);
    chk(reg_rdata, 8'h01);
    {code_rewrite, df_rewrite, stop_req, reg_wr} = 4'b0001;
    tick;
    reg_wr = 0;
    chk(reg_rdata, 0);
    chk(df_grant, 0);
    {stop_req, reg_addr, df_fetch} = {1'b1, 20'hf0091, 1'b1};
    tick;
    chk(stop_ok, 1);
    chk(reg_rdata, 0);
    chk(df_fetch_err, 1);
    finish_test;
  end
endmodule
